//--- hw/bit_sync.sv
// Two-flop synchroniser for one level into a clock domain
`timescale 1ns/1ps
module bit_sync
	import dpi_timing_pkg::*;
(
	// Destination domain
	input  wire logic clk,
	input  wire logic rst_n,
	// Level in and out
	input  wire logic d,
	output logic      q
);

	logic meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

//--- hw/dpi_timing_pkg.sv
// Package with register map, field layout and limits of the video timing generator
package dpi_timing_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int FIELD_W = 11;
	localparam int SUM_W   = 13;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] HSYNC_HBP_OFS = 8'h04;
	localparam logic [7:0] HACT_HFP_OFS  = 8'h08;
	localparam logic [7:0] VSYNC_VBP_OFS = 8'h0c;
	localparam logic [7:0] VACT_VFP_OFS  = 8'h10;
	localparam logic [7:0] POLARITY_OFS  = 8'h14;
	localparam logic [7:0] STATUS_OFS    = 8'h18;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_VIDEO_BIT    = 1;
	localparam int CTRL_APPLY_BIT    = 2;
	localparam int CTRL_RGB565_BIT   = 3;
	localparam int LO_FIELD_LSB      = 0;
	localparam int HI_FIELD_LSB      = 16;
	localparam int POL_HSYNC_BIT     = 0;
	localparam int POL_VSYNC_BIT     = 1;
	localparam int POL_ACTIVE_BIT    = 2;
	localparam int STAT_BUSY_BIT     = 0;
	localparam int STAT_HERR_BIT     = 1;
	localparam int STAT_VERR_BIT     = 2;
	localparam int STAT_RUN_BIT      = 3;
	localparam int STAT_FRAMES_LSB   = 16;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [3:0]  CTRL_RESET      = 4'h0;
	localparam logic [31:0] TIMING_RESET    = 32'h0000_0000;
	localparam logic [2:0]  POLARITY_RESET  = 3'h0;

	// ****************************************
	// Limits and stride padding
	// ****************************************
	localparam logic [SUM_W-1:0] MAX_LINE_PIXELS  = 13'h0400;
	localparam logic [SUM_W-1:0] MAX_FRAME_LINES  = 13'h0300;
	localparam logic [SUM_W-1:0] STRIDE_PIX_MASK  = 13'h003f;

endpackage

//--- hw/dpi_video_timing_generator.sv
// Video timing generator: APB registers on pclk, timing counters on the pixel clock
// How it works
// R1 - Every line opens with a horizontal sync pulse lasting the programmed sync width in pixel clocks.
// R2 - After the horizontal sync comes an idle back porch of the programmed pixel count before the first active pixel.
// R3 - After the last active pixel comes an idle front porch of the programmed length before the next horizontal sync.
// R4 - The line length in pixel clocks is sync width plus back porch plus active width plus front porch.
// R5 - The vertical sync pulse lasts a programmed number of whole lines.
// R6 - After vertical sync come the programmed number of idle back-porch lines before the first active line.
// R7 - After the last active line come the programmed number of idle front-porch lines before the next vertical sync.
// R8 - The frame length in lines is sync width plus back porch plus active height plus front porch.
// R9 - The pixel clock supplied from outside equals line total times frame total times frame rate.
// R10 - The serial link lane rate must cover pixel clock times bits per pixel over lane count, 24 bits for 24-bit coding.
// R11 - With 16-bit pixels the active width is padded up so each line stride is a multiple of 128 bytes.
// R12 - Separate polarity bits pick the active level of horizontal sync, vertical sync and pixel enable, zero meaning high.
// R13 - Polarity bits act only in video mode and are ignored when the command-mode path drives the display.
// R14 - Line totals up to 1024 pixels and frame totals up to 768 lines are supported, larger ones refused.
// R15 - Pixel enable is high only inside both active regions, and both counters restart at every frame start.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module dpi_video_timing_generator
	import dpi_timing_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Pixel link
	input  wire logic        pix_clk,
	output logic             hsync_out,
	output logic             vsync_out,
	output logic             active_pixel_enable,
	output logic             frame_start
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [SUM_W-1:0] widen(input logic [FIELD_W-1:0] f);
		widen = {{(SUM_W-FIELD_W){1'b0}}, f};
	endfunction

	function automatic logic [FIELD_W-1:0] lo_field(input logic [31:0] w);
		lo_field = w[LO_FIELD_LSB +: FIELD_W];
	endfunction

	function automatic logic [FIELD_W-1:0] hi_field(input logic [31:0] w);
		hi_field = w[HI_FIELD_LSB +: FIELD_W];
	endfunction

	// ****************************************
	// Register file (pclk)
	// ****************************************
	logic [3:0]         ctrl_reg;
	logic [31:0]        hsync_hbp_reg;
	logic [31:0]        hact_hfp_reg;
	logic [31:0]        vsync_vbp_reg;
	logic [31:0]        vact_vfp_reg;
	logic [2:0]         pol_reg;
	logic               herr_reg;
	logic               verr_reg;
	logic [15:0]        frames_reg;
	logic               req_tgl_reg;
	logic               ack_sync;
	logic               frm_sync;
	logic               frm_seen_reg;
	logic               busy;
	logic               wr_en;
	logic               rd_en;
	logic               addr_ok;
	logic               apply_req;

	// Shadow words handed to the pixel domain, stable while busy
	logic [FIELD_W-1:0] x_hse_reg;
	logic [FIELD_W-1:0] x_has_reg;
	logic [FIELD_W-1:0] x_hae_reg;
	logic [FIELD_W-1:0] x_htot_reg;
	logic [FIELD_W-1:0] x_vse_reg;
	logic [FIELD_W-1:0] x_vas_reg;
	logic [FIELD_W-1:0] x_vae_reg;
	logic [FIELD_W-1:0] x_vtot_reg;
	logic [2:0]         x_pol_reg;

	// Boundary sums from the live registers
	logic [SUM_W-1:0]   hact_pad;
	logic [SUM_W-1:0]   h_se;
	logic [SUM_W-1:0]   h_as;
	logic [SUM_W-1:0]   h_ae;
	logic [SUM_W-1:0]   h_tot;
	logic [SUM_W-1:0]   v_se;
	logic [SUM_W-1:0]   v_as;
	logic [SUM_W-1:0]   v_ae;
	logic [SUM_W-1:0]   v_tot;
	logic               h_bad;
	logic               v_bad;

	assign busy    = req_tgl_reg != ack_sync;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign apply_req = wr_en && addr_ok && (paddr == CTRL_OFS) && pwdata[CTRL_APPLY_BIT];

	always_comb begin
		case (paddr)
			CTRL_OFS, HSYNC_HBP_OFS, HACT_HFP_OFS, VSYNC_VBP_OFS,
			VACT_VFP_OFS, POLARITY_OFS, STATUS_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !addr_ok;

	// 16-bit pixels: 64 pixels make a 128-byte stride, so round width up
	always_comb begin
		if (ctrl_reg[CTRL_RGB565_BIT]) begin
			hact_pad = (widen(lo_field(hact_hfp_reg)) + STRIDE_PIX_MASK) & ~STRIDE_PIX_MASK; // R11
		end else begin
			hact_pad = widen(lo_field(hact_hfp_reg));
		end
	end

	assign h_se  = widen(lo_field(hsync_hbp_reg));
	assign h_as  = h_se + widen(hi_field(hsync_hbp_reg));
	assign h_ae  = h_as + hact_pad;
	assign h_tot = h_ae + widen(hi_field(hact_hfp_reg)); // R4
	assign v_se  = widen(lo_field(vsync_vbp_reg));
	assign v_as  = v_se + widen(hi_field(vsync_vbp_reg));
	assign v_ae  = v_as + widen(lo_field(vact_vfp_reg));
	assign v_tot = v_ae + widen(hi_field(vact_vfp_reg)); // R8
	assign h_bad = (h_tot > MAX_LINE_PIXELS) || (h_tot == '0); // R14
	assign v_bad = (v_tot > MAX_FRAME_LINES) || (v_tot == '0); // R14

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg      <= CTRL_RESET;
			hsync_hbp_reg <= TIMING_RESET;
			hact_hfp_reg  <= TIMING_RESET;
			vsync_vbp_reg <= TIMING_RESET;
			vact_vfp_reg  <= TIMING_RESET;
			pol_reg       <= POLARITY_RESET;
		end else if (wr_en) begin
			case (paddr)
				CTRL_OFS: begin
					ctrl_reg <= {pwdata[CTRL_RGB565_BIT], 1'b0, pwdata[CTRL_VIDEO_BIT], pwdata[CTRL_ENABLE_BIT]};
				end
				HSYNC_HBP_OFS: hsync_hbp_reg <= pwdata;
				HACT_HFP_OFS:  hact_hfp_reg  <= pwdata;
				VSYNC_VBP_OFS: vsync_vbp_reg <= pwdata;
				VACT_VFP_OFS:  vact_vfp_reg  <= pwdata;
				POLARITY_OFS:  pol_reg       <= pwdata[2:0]; // R12
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Apply: check, latch shadow, toggle request
	// ****************************************
	// An apply while busy is dropped; software polls the busy bit first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_tgl_reg <= 1'b0;
			herr_reg    <= 1'b0;
			verr_reg    <= 1'b0;
			x_hse_reg   <= '0;
			x_has_reg   <= '0;
			x_hae_reg   <= '0;
			x_htot_reg  <= '0;
			x_vse_reg   <= '0;
			x_vas_reg   <= '0;
			x_vae_reg   <= '0;
			x_vtot_reg  <= '0;
			x_pol_reg   <= '0;
		end else if (apply_req && !busy) begin
			herr_reg <= h_bad;
			verr_reg <= v_bad;
			if (!h_bad && !v_bad) begin
				x_hse_reg   <= h_se[FIELD_W-1:0];
				x_has_reg   <= h_as[FIELD_W-1:0];
				x_hae_reg   <= h_ae[FIELD_W-1:0];
				x_htot_reg  <= h_tot[FIELD_W-1:0];
				x_vse_reg   <= v_se[FIELD_W-1:0];
				x_vas_reg   <= v_as[FIELD_W-1:0];
				x_vae_reg   <= v_ae[FIELD_W-1:0];
				x_vtot_reg  <= v_tot[FIELD_W-1:0];
				// Command mode drives plain active-high levels
				x_pol_reg   <= ctrl_reg[CTRL_VIDEO_BIT] ? pol_reg : 3'h0; // R13
				req_tgl_reg <= !req_tgl_reg;
			end
		end
	end

	// ****************************************
	// Frame counter and read data
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm_seen_reg <= 1'b0;
			frames_reg   <= '0;
		end else begin
			frm_seen_reg <= frm_sync;
			if (frm_sync != frm_seen_reg) begin
				frames_reg <= frames_reg + 16'h0001;
			end
		end
	end

	logic run_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_en) begin
			case (paddr)
				CTRL_OFS:      prdata <= {28'h0000000, ctrl_reg};
				HSYNC_HBP_OFS: prdata <= hsync_hbp_reg;
				HACT_HFP_OFS:  prdata <= hact_hfp_reg;
				VSYNC_VBP_OFS: prdata <= vsync_vbp_reg;
				VACT_VFP_OFS:  prdata <= vact_vfp_reg;
				POLARITY_OFS:  prdata <= {29'h0, pol_reg};
				STATUS_OFS:    prdata <= {frames_reg, 12'h000, run_sync, verr_reg, herr_reg, busy};
				default:       prdata <= '0;
			endcase
		end
	end

	// ****************************************
	// Crossings
	// ****************************************
	logic pix_rst_n;
	logic en_sync;
	logic req_sync;
	logic req_seen_reg;
	logic frm_tgl_reg;
	logic run;

	// Reset asserts at once, releases on the pixel clock
	bit_sync u_rst_sync (
		.clk   (pix_clk),
		.rst_n (presetn),
		.d     (1'b1),
		.q     (pix_rst_n)
	);

	bit_sync u_en_sync (
		.clk   (pix_clk),
		.rst_n (pix_rst_n),
		.d     (ctrl_reg[CTRL_ENABLE_BIT]),
		.q     (en_sync)
	);

	bit_sync u_req_sync (
		.clk   (pix_clk),
		.rst_n (pix_rst_n),
		.d     (req_tgl_reg),
		.q     (req_sync)
	);

	bit_sync u_ack_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (req_seen_reg),
		.q     (ack_sync)
	);

	bit_sync u_frm_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (frm_tgl_reg),
		.q     (frm_sync)
	);

	bit_sync u_run_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (run),
		.q     (run_sync)
	);

	// ****************************************
	// Pixel domain timing
	// ****************************************
	logic [FIELD_W-1:0] hse_reg;
	logic [FIELD_W-1:0] has_reg;
	logic [FIELD_W-1:0] hae_reg;
	logic [FIELD_W-1:0] htot_reg;
	logic [FIELD_W-1:0] vse_reg;
	logic [FIELD_W-1:0] vas_reg;
	logic [FIELD_W-1:0] vae_reg;
	logic [FIELD_W-1:0] vtot_reg;
	logic [2:0]         pix_pol_reg;
	logic               cfg_valid_reg;
	logic [FIELD_W-1:0] h_reg;
	logic [FIELD_W-1:0] v_reg;
	logic               line_end;
	logic               frame_end;
	logic               load;
	logic               hs_lvl;
	logic               vs_lvl;
	logic               de_lvl;

	assign run       = en_sync && cfg_valid_reg;
	assign line_end  = h_reg == htot_reg - 11'h001;
	assign frame_end = line_end && (v_reg == vtot_reg - 11'h001);
	// New timing is taken only between frames so a frame is never torn
	assign load      = (req_sync != req_seen_reg) && (!run || frame_end);

	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			req_seen_reg  <= 1'b0;
			cfg_valid_reg <= 1'b0;
			hse_reg       <= '0;
			has_reg       <= '0;
			hae_reg       <= '0;
			htot_reg      <= '0;
			vse_reg       <= '0;
			vas_reg       <= '0;
			vae_reg       <= '0;
			vtot_reg      <= '0;
			pix_pol_reg   <= '0;
		end else if (load) begin
			req_seen_reg  <= req_sync;
			cfg_valid_reg <= 1'b1;
			hse_reg       <= x_hse_reg;
			has_reg       <= x_has_reg;
			hae_reg       <= x_hae_reg;
			htot_reg      <= x_htot_reg;
			vse_reg       <= x_vse_reg;
			vas_reg       <= x_vas_reg;
			vae_reg       <= x_vae_reg;
			vtot_reg      <= x_vtot_reg;
			pix_pol_reg   <= x_pol_reg;
		end
	end

	// Counters start from the sync pulse of line 0
	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			h_reg <= '0;
			v_reg <= '0;
		end else if (!run || load) begin
			h_reg <= '0; // R15
			v_reg <= '0; // R15
		end else if (line_end) begin
			h_reg <= '0; // R4
			if (frame_end) begin
				v_reg <= '0; // R8 R15
			end else begin
				v_reg <= v_reg + 11'h001;
			end
		end else begin
			h_reg <= h_reg + 11'h001;
		end
	end

	assign hs_lvl = run && (h_reg < hse_reg); // R1 R3
	assign vs_lvl = run && (v_reg < vse_reg); // R5 R7
	assign de_lvl = run && (h_reg >= has_reg) && (h_reg < hae_reg)
		&& (v_reg >= vas_reg) && (v_reg < vae_reg); // R2 R3 R6 R7 R15

	always_ff @(posedge pix_clk or negedge pix_rst_n) begin
		if (!pix_rst_n) begin
			hsync_out           <= 1'b0;
			vsync_out           <= 1'b0;
			active_pixel_enable <= 1'b0;
			frame_start         <= 1'b0;
			frm_tgl_reg         <= 1'b0;
		end else begin
			hsync_out           <= hs_lvl ^ pix_pol_reg[POL_HSYNC_BIT]; // R12
			vsync_out           <= vs_lvl ^ pix_pol_reg[POL_VSYNC_BIT]; // R12
			active_pixel_enable <= de_lvl ^ pix_pol_reg[POL_ACTIVE_BIT]; // R12
			frame_start         <= run && !load && (h_reg == '0) && (v_reg == '0);
			if (run && !load && (h_reg == '0) && (v_reg == '0)) begin
				frm_tgl_reg <= !frm_tgl_reg;
			end
		end
	end

endmodule

//--- tb/display_sink.sv
// Display host model: measures line and frame figures on the pixel link
`timescale 1ns/1ps
module display_sink (
	// Pixel link
	input wire logic        pix_clk,
	input wire logic        hsync_out,
	input wire logic        vsync_out,
	input wire logic        active_pixel_enable,
	input wire logic        frame_start,
	// Active-low mask per signal
	input wire logic [2:0]  pol,
	// Line, hsync, enable start, enable width, frame, vsync, first active line, active lines
	output logic     [15:0] meas [8]
);
	logic        hs;
	logic        vs;
	logic        en;
	logic        hs_d;
	logic        vs_d;
	logic        en_d;
	logic [15:0] hcnt;
	logic [15:0] vcnt;
	logic [15:0] nact;
	assign hs = hsync_out ^ pol[0];
	assign vs = vsync_out ^ pol[1];
	assign en = active_pixel_enable ^ pol[2];
	// Pixels taken at pixel rate; host lanes assumed to carry 24 bits each
	// Positions count from the hsync leading edge
	always_ff @(posedge pix_clk) begin
		hs_d <= hs;
		vs_d <= vs;
		en_d <= en;
		hcnt <= (hs && !hs_d) ? 16'h0001 : hcnt + 16'h0001;
		if (hs && !hs_d) begin
			meas[0] <= hcnt;
			vcnt <= frame_start ? 16'h0001 : vcnt + 16'h0001;
		end
		if (!hs && hs_d) meas[1] <= hcnt;
		if (en && !en_d) begin
			meas[2] <= hcnt;
			nact <= nact + 16'h0001;
			if (nact == 16'h0000) meas[6] <= vcnt - 16'h0001;
		end
		if (!en && en_d) meas[3] <= hcnt - meas[2];
		if (!vs && vs_d) meas[5] <= vcnt;
		if (frame_start) begin
			meas[4] <= vcnt;
			meas[7] <= nact;
			nact <= 16'h0000;
		end
	end
endmodule

//--- tb/dpi_timing_checker_asserts.sv
// Checker of bus answers and frame marker of the video timing generator
`timescale 1ns/1ps
module dpi_timing_checker
	import dpi_timing_pkg::*;
(
	// APB side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pixel side
	input wire logic        pix_clk,
	input wire logic        frame_start
);
	// ****************************************
	// Decode and phases
	// ****************************************
	logic mapped;
	assign mapped = paddr inside {CTRL_OFS, HSYNC_HBP_OFS, HACT_HFP_OFS, VSYNC_VBP_OFS,
		VACT_VFP_OFS, POLARITY_OFS, STATUS_OFS};
	sequence s_access; psel && penable; endsequence
	sequence s_rd_setup; psel && !penable && !pwrite; endsequence

	// ****************************************
	// Properties
	// ****************************************
	property p_ready; @(posedge pclk) disable iff (!presetn) s_access |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access phase");
	property p_err_phase; @(posedge pclk) disable iff (!presetn) pslverr |-> psel && penable; endproperty
	a_err_phase: assert property (p_err_phase) else $error("pslverr outside access phase");
	property p_err_bad; @(posedge pclk) disable iff (!presetn) psel && penable && !mapped |-> pslverr; endproperty
	a_err_bad: assert property (p_err_bad) else $error("no error on unmapped address");
	property p_err_ok; @(posedge pclk) disable iff (!presetn) psel && penable && mapped |-> !pslverr; endproperty
	a_err_ok: assert property (p_err_ok) else $error("error on mapped address");
	// Read data may only move at a read setup edge
	property p_rd_hold; @(posedge pclk) disable iff (!presetn) !(psel && !penable && !pwrite) |=> $stable(prdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside read setup");
	property p_rd_zero; @(posedge pclk) disable iff (!presetn) s_rd_setup ##0 !mapped |=> prdata == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
	property p_apply_rd; @(posedge pclk) disable iff (!presetn)
		s_rd_setup ##0 paddr == CTRL_OFS |=> !prdata[CTRL_APPLY_BIT]; endproperty
	a_apply_rd: assert property (p_apply_rd) else $error("apply bit reads back set");
	property p_fs_pulse; @(posedge pix_clk) disable iff (!presetn) frame_start |=> !frame_start; endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("frame start longer than one cycle");
endmodule

bind dpi_video_timing_generator dpi_timing_checker u_dpi_timing_checker (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .pix_clk, .frame_start);

//--- tb/tb.sv
// Testbench of the video timing generator with a display host model
`timescale 1ns/1ps
module tb
	import dpi_timing_pkg::*;
;
	// ****************************************
	// Signals and counters
	// ****************************************
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pix_clk;
	logic        hsync_out;
	logic        vsync_out;
	logic        active_pixel_enable;
	logic        frame_start;
	logic [2:0]  pol;
	logic [15:0] meas [8];
	logic [15:0] t [8];
	logic [31:0] rd;
	logic        err;
	logic [2:0]  pv [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	dpi_video_timing_generator u_dpi_video_timing_generator (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pix_clk, .hsync_out, .vsync_out, .active_pixel_enable, .frame_start);
	display_sink u_display_sink (.pix_clk, .hsync_out, .vsync_out, .active_pixel_enable, .frame_start, .pol, .meas);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Pixel clock kept out of phase with the bus clock
	initial begin
		pix_clk = 1'b0;
		#3.3;
		forever #7.5 pix_clk = ~pix_clk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors++;
			test_done();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic test_done();
		$display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Fields first, then control, then the same control with apply, then wait for the load
	task automatic load(input logic [3:0] c, input logic [2:0] p);
		for (int i = 0; i < 4; i++) apb(1'b1, HSYNC_HBP_OFS + 8'(4 * i), {5'h0, t[2*i+1][10:0], 5'h0, t[2*i][10:0]});
		apb(1'b1, POLARITY_OFS, {29'h0, p});
		apb(1'b1, CTRL_OFS, {28'h0, c});
		apb(1'b1, CTRL_OFS, {28'h0, c | 4'h4});
		apb(1'b0, STATUS_OFS, 32'h0);
		while (rd[STAT_BUSY_BIT] === 1'b1) apb(1'b0, STATUS_OFS, 32'h0);
	endtask
	task automatic check_timing(input logic [15:0] ha);
		logic [15:0] f0;
		logic [15:0] e [8];
		apb(1'b0, STATUS_OFS, 32'h0);
		f0 = rd[31:16];
		while (16'(rd[31:16] - f0) < 16'h0003) apb(1'b0, STATUS_OFS, 32'h0);
		e = '{t[0] + t[1] + ha + t[3], t[0], t[0] + t[1], ha, t[4] + t[5] + t[6] + t[7], t[4], t[4] + t[5], t[6]};
		for (int i = 0; i < 8; i++) chk($sformatf("measure %0d", i), 32'(e[i]), 32'(meas[i]));
		chk("running flag", 32'h1, 32'(rd[STAT_RUN_BIT]));
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", 32'h0, rd);
			chk("mapped error", 32'h0, 32'(err));
		end
		apb(1'b1, 8'h1c, 32'hffff_ffff);
		chk("unmapped write error", 32'h1, 32'(err));
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped read data", 32'h0, rd);
		chk("unmapped read error", 32'h1, 32'(err));
	endtask
	task automatic t_video(input logic [2:0] p);
		t = '{16'h0003, 16'h0004, 16'h000a, 16'h0005, 16'h0002, 16'h0003, 16'h0004, 16'h0002};
		pol <= p;
		load(4'h3, p);
		check_timing(t[2]);
	endtask
	task automatic t_rgb565();
		t[2] = 16'h0041;
		pol <= 3'h0;
		load(4'hb, 3'h0);
		check_timing(16'h0080);
	endtask
	// Command mode drives active-high levels whatever the polarity register says
	task automatic t_cmd();
		t[2] = 16'h000a;
		pol <= 3'h0;
		load(4'h1, 3'h7);
		check_timing(t[2]);
	endtask
	task automatic t_limit();
		t = '{16'h0003, 16'h0004, 16'h03f5, 16'h0005, 16'h0002, 16'h0003, 16'h02fa, 16'h0002};
		load(4'h3, 3'h0);
		chk("limit flags over", 32'h3, 32'(rd[2:1]));
		t[2] = 16'h03f4;
		t[6] = 16'h02f9;
		load(4'h3, 3'h0);
		chk("limit flags at max", 32'h0, 32'(rd[2:1]));
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pol = 3'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		foreach (pv[i]) t_video(pv[i]);
		t_rgb565();
		t_cmd();
		t_limit();
		test_done();
	end
endmodule
